// file: src/vps_defs.vh
// constants for the voltage protection and operation status register bank
`ifndef VPS_DEFS_VH
`define VPS_DEFS_VH
// command codes
`define VPS_CMD_NOP 4'h0
`define VPS_CMD_NEG_PROT_SET 4'h1
`define VPS_CMD_POS_PROT_SET 4'h2
`define VPS_CMD_CEIL_BOTH_SET 4'h3
`define VPS_CMD_CEIL_NEG_SET 4'h4
`define VPS_CMD_CEIL_POS_SET 4'h5
`define VPS_CMD_TRIG_VOLT_SET 4'h6
`define VPS_CMD_TRIGGER 4'h7
`define VPS_CMD_SAVE 4'h8
`define VPS_CMD_STAT_PRESET 4'h9
`define VPS_CMD_OPER_MASK_SET 4'hA
// query codes
`define VPS_QRY_NEG_PROT 4'h1
`define VPS_QRY_POS_PROT 4'h2
`define VPS_QRY_CEIL_BOTH 4'h3
`define VPS_QRY_CEIL_NEG 4'h4
`define VPS_QRY_CEIL_POS 4'h5
`define VPS_QRY_TRIG_VOLT 4'h6
`define VPS_QRY_OPER_COND 4'h7
`define VPS_QRY_OPER_MASK 4'h8
`define VPS_QRY_OPER_EVENT 4'h9
// status bit positions
`define VPS_BIT_SETTLING 1
`define VPS_BIT_TRIG_WAIT 5
`define VPS_BIT_PULSE_ARMED 6
`define VPS_BIT_SUMMARY 7
`define VPS_BIT_CONST_VOLT 8
`define VPS_BIT_PULSE_DONE 9
`define VPS_BIT_CONST_CURR 10
`define VPS_BIT_SAMPLE_DONE 11
`define VPS_BIT_SEQ_DONE 12
`define VPS_BIT_SEQ_RUN 14
`define VPS_OPER_USED_MASK 16'h5F62
// preset values and range error code
`define VPS_PRESET_OPER_MASK 16'h2001
`define VPS_PRESET_QUES_MASK 16'h00FF
`define VPS_ERR_OUT_OF_RANGE 16'hFF22
`endif

// file: src/vps_bank.v
// voltage protection limits, triggered setpoint and operation status group
// What this block does
// - host sets negative protection limit, stored
// - host sets positive protection limit, stored
// - negative limit query returns stored value
// - positive limit query returns stored value
// - combined ceiling loads both ceilings, save persists
// - combined ceiling query: positive then negative
// - negative ceiling command sets negative ceiling
// - positive ceiling command sets positive ceiling
// - per side ceiling queries return stored ceiling
// - pending trigger voltage applied on trigger
// - over model maximum posts error -222
// - over user high limit stores limit
// - trigger voltage query returns pending value
// - condition register shows live state
// - constant current bit 10, voltage bit 8
// - remaining flags at their fixed bit positions
// - summary is OR of enabled event bits
// - enable mask writable and readable
// - event register latches until read
// - reading event register clears it
// - preset loads enable 8193, questionable 255
`timescale 1ns/100ps
`include "vps_defs.vh"
module vps_bank #(
	parameter VW = 16,
	parameter [VW-1:0] MODEL_MAX = 16'h03E8,
	parameter [VW-1:0] RATED_PLUS1 = 16'h03F2
)(
	input wire I_CORE_CLK,
	input wire I_RST,
	input wire i_cmd_valid,
	input wire [3:0] i_cmd_code,
	input wire [VW-1:0] i_cmd_value,
	input wire i_qry_valid,
	input wire [3:0] i_qry_code,
	input wire [VW-1:0] i_user_high_voltage_limit,
	input wire [VW-1:0] i_saved_neg_prot,
	input wire [VW-1:0] i_saved_pos_prot,
	input wire [VW-1:0] i_saved_neg_ceil,
	input wire [VW-1:0] i_saved_pos_ceil,
	input wire i_settling_flag,
	input wire i_trigger_wait_flag,
	input wire i_pulse_armed_flag,
	input wire i_const_voltage_flag,
	input wire i_pulse_done_flag,
	input wire i_const_current_flag,
	input wire i_sample_done_flag,
	input wire i_sequence_done_flag,
	input wire i_sequence_running_flag,
	output reg o_rsp_valid,
	output reg o_rsp_two,
	output reg [VW-1:0] o_rsp_data0,
	output reg [VW-1:0] o_rsp_data1,
	output reg [VW-1:0] o_setpoint,
	output reg [VW-1:0] o_neg_prot,
	output reg [VW-1:0] o_pos_prot,
	output reg o_save_pulse,
	output reg [VW-1:0] o_save_neg_ceil,
	output reg [VW-1:0] o_save_pos_ceil,
	output reg o_err_valid,
	output reg [15:0] o_err_code,
	output reg o_oper_summary,
	output reg [15:0] o_ques_mask
);

// ----------------------------------------
// state
// ----------------------------------------
reg [VW-1:0] neg_ceil_reg;
reg [VW-1:0] pos_ceil_reg;
reg [VW-1:0] pending_reg;
reg [15:0] oper_live_state_reg;
reg [15:0] oper_latched_events_reg;
reg [15:0] oper_summary_mask_reg;
reg [15:0] raw_cond;
reg capture_done_reg;
wire [15:0] rise;
wire [15:0] oper_latched_events_next;
wire [VW-1:0] ceil_val;
wire ev_read;
wire cmd_ok;
wire [VW-1:0] val_clamped;

// ----------------------------------------
// live condition map
// ----------------------------------------
always @*
begin
	raw_cond = 16'h0000;
	raw_cond[`VPS_BIT_SETTLING] = i_settling_flag;
	raw_cond[`VPS_BIT_TRIG_WAIT] = i_trigger_wait_flag;
	raw_cond[`VPS_BIT_PULSE_ARMED] = i_pulse_armed_flag;
	raw_cond[`VPS_BIT_CONST_VOLT] = i_const_voltage_flag;
	raw_cond[`VPS_BIT_PULSE_DONE] = i_pulse_done_flag;
	raw_cond[`VPS_BIT_CONST_CURR] = i_const_current_flag;
	raw_cond[`VPS_BIT_SAMPLE_DONE] = i_sample_done_flag;
	raw_cond[`VPS_BIT_SEQ_DONE] = i_sequence_done_flag;
	raw_cond[`VPS_BIT_SEQ_RUN] = i_sequence_running_flag;
end

// rise is judged against the registered copy, so an event lands one cycle
// after the flag rises, together with the condition bit
assign rise = raw_cond & ~oper_live_state_reg;
assign ev_read = i_qry_valid && (i_qry_code == `VPS_QRY_OPER_EVENT);
assign cmd_ok = i_cmd_valid;
// clamp to user high limit after the range check
assign val_clamped = (i_cmd_value > i_user_high_voltage_limit) ?
	i_user_high_voltage_limit : i_cmd_value;

// commanded ceilings never go past the rated value plus one percent
assign ceil_val = (i_cmd_value > RATED_PLUS1) ? RATED_PLUS1 : i_cmd_value;

// ----------------------------------------
// per bit event latch
// ----------------------------------------
// a rise on the read edge survives the clear, so no event is lost between
// two reads; the read itself returns the value from before the edge
genvar gb;
generate
	for (gb = 0; gb < 16; gb = gb + 1)
	begin : g_event_bit
		assign oper_latched_events_next[gb] = rise[gb] |
			(oper_latched_events_reg[gb] & ~ev_read);
	end
endgenerate

// ----------------------------------------
// live condition and event register
// ----------------------------------------
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		oper_live_state_reg <= 16'h0000;
		oper_latched_events_reg <= 16'h0000;
	end
	else
	begin
		oper_live_state_reg <= raw_cond;
		oper_latched_events_reg <= oper_latched_events_next;
	end
end

// ----------------------------------------
// enable mask and preset
// ----------------------------------------
// preset leaves the live and event registers alone; only the masks move
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		oper_summary_mask_reg <= 16'h0000;
		o_ques_mask <= 16'h0000;
	end
	else if (cmd_ok && i_cmd_code == `VPS_CMD_STAT_PRESET)
	begin
		oper_summary_mask_reg <= `VPS_PRESET_OPER_MASK;
		o_ques_mask <= `VPS_PRESET_QUES_MASK;
	end
	else if (cmd_ok && i_cmd_code == `VPS_CMD_OPER_MASK_SET)
		oper_summary_mask_reg <= i_cmd_value[15:0];
end

// ----------------------------------------
// operation summary
// ----------------------------------------
// built from the registered event and mask pair, so it trails an event by one cycle
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
		o_oper_summary <= 1'b0;
	else
		o_oper_summary <= |(oper_latched_events_reg & oper_summary_mask_reg);
end

// ----------------------------------------
// limits and ceilings
// ----------------------------------------
// saved power-up values are caught on the first edge after release;
// a command on that edge is dropped by the limit and ceiling registers
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
		capture_done_reg <= 1'b0;
	else
		capture_done_reg <= 1'b1;
end

always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		o_neg_prot <= {VW{1'b0}};
		o_pos_prot <= {VW{1'b0}};
	end
	else if (!capture_done_reg)
	begin
		o_neg_prot <= i_saved_neg_prot;
		o_pos_prot <= i_saved_pos_prot;
	end
	else if (cmd_ok)
	begin
		if (i_cmd_code == `VPS_CMD_NEG_PROT_SET)
			o_neg_prot <= i_cmd_value;
		if (i_cmd_code == `VPS_CMD_POS_PROT_SET)
			o_pos_prot <= i_cmd_value;
	end
end

// limits are not held under the ceilings here; the host keeps them in range
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		neg_ceil_reg <= {VW{1'b0}};
		pos_ceil_reg <= {VW{1'b0}};
	end
	else if (!capture_done_reg)
	begin
		neg_ceil_reg <= i_saved_neg_ceil;
		pos_ceil_reg <= i_saved_pos_ceil;
	end
	else if (cmd_ok)
	begin
		if (i_cmd_code == `VPS_CMD_CEIL_BOTH_SET || i_cmd_code == `VPS_CMD_CEIL_NEG_SET)
			neg_ceil_reg <= ceil_val;
		if (i_cmd_code == `VPS_CMD_CEIL_BOTH_SET || i_cmd_code == `VPS_CMD_CEIL_POS_SET)
			pos_ceil_reg <= ceil_val;
	end
end

// ----------------------------------------
// pending setpoint and range error
// ----------------------------------------
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		pending_reg <= {VW{1'b0}};
		o_setpoint <= {VW{1'b0}};
		o_err_valid <= 1'b0;
		o_err_code <= 16'h0000;
	end
	else
	begin
		o_err_valid <= 1'b0;
		if (cmd_ok)
		begin
			case (i_cmd_code)
				`VPS_CMD_TRIG_VOLT_SET:
				begin
					// an over-range value is refused, not clamped
					if (i_cmd_value > MODEL_MAX)
					begin
						o_err_valid <= 1'b1;
						o_err_code <= `VPS_ERR_OUT_OF_RANGE;
					end
					else
						pending_reg <= val_clamped;
				end
				`VPS_CMD_TRIGGER:
					o_setpoint <= pending_reg;
				default:
					o_err_valid <= 1'b0;
			endcase
		end
	end
end

// ----------------------------------------
// save request
// ----------------------------------------
// the snapshot is taken from the ceilings as they stand before this edge
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		o_save_pulse <= 1'b0;
		o_save_neg_ceil <= {VW{1'b0}};
		o_save_pos_ceil <= {VW{1'b0}};
	end
	else
	begin
		o_save_pulse <= 1'b0;
		if (cmd_ok && i_cmd_code == `VPS_CMD_SAVE)
		begin
			o_save_pulse <= 1'b1;
			o_save_neg_ceil <= neg_ceil_reg;
			o_save_pos_ceil <= pos_ceil_reg;
		end
	end
end

// ----------------------------------------
// query answers, one cycle after the query
// ----------------------------------------
always @(posedge I_CORE_CLK or posedge I_RST)
begin
	if (I_RST)
	begin
		o_rsp_valid <= 1'b0;
		o_rsp_two <= 1'b0;
		o_rsp_data0 <= {VW{1'b0}};
		o_rsp_data1 <= {VW{1'b0}};
	end
	else
	begin
		// second value and pair flag stay zero unless the combined ceiling is asked
		o_rsp_valid <= i_qry_valid;
		o_rsp_two <= 1'b0;
		o_rsp_data1 <= {VW{1'b0}};
		if (i_qry_valid)
		begin
			case (i_qry_code)
				`VPS_QRY_NEG_PROT:
					o_rsp_data0 <= o_neg_prot;
				`VPS_QRY_POS_PROT:
					o_rsp_data0 <= o_pos_prot;
				`VPS_QRY_CEIL_BOTH:
				begin
					o_rsp_two <= 1'b1;
					o_rsp_data0 <= pos_ceil_reg;
					o_rsp_data1 <= neg_ceil_reg;
				end
				`VPS_QRY_CEIL_NEG:
					o_rsp_data0 <= neg_ceil_reg;
				`VPS_QRY_CEIL_POS:
					o_rsp_data0 <= pos_ceil_reg;
				`VPS_QRY_TRIG_VOLT:
					o_rsp_data0 <= pending_reg;
				`VPS_QRY_OPER_COND:
					o_rsp_data0 <= oper_live_state_reg[VW-1:0];
				`VPS_QRY_OPER_MASK:
					o_rsp_data0 <= oper_summary_mask_reg[VW-1:0];
				`VPS_QRY_OPER_EVENT:
					o_rsp_data0 <= oper_latched_events_reg[VW-1:0];
				default:
					o_rsp_data0 <= {VW{1'b0}};
			endcase
		end
	end
end

endmodule

// file: tb/vps_bank_chk.sv
// port assertions for the register bank
`timescale 1ns/100ps
module vps_chk #(parameter VW = 16)(
	input wire I_CORE_CLK,
	input wire I_RST,
	input wire i_cmd_valid,
	input wire [3:0] i_cmd_code,
	input wire [VW-1:0] i_cmd_value,
	input wire i_qry_valid,
	input wire [3:0] i_qry_code,
	input wire o_rsp_valid,
	input wire o_rsp_two,
	input wire [VW-1:0] o_setpoint,
	input wire [VW-1:0] o_neg_prot,
	input wire [VW-1:0] o_pos_prot,
	input wire o_save_pulse,
	input wire o_err_valid,
	input wire [15:0] o_err_code,
	input wire [15:0] o_ques_mask
);
default clocking @(posedge I_CORE_CLK); endclocking
default disable iff (I_RST);
wire c = i_cmd_valid;
property p_rsp; i_qry_valid |=> o_rsp_valid; endproperty
a_rsp: assert property (p_rsp) else $error("query not answered");
property p_two; i_qry_valid && i_qry_code == 4'h3 |=> o_rsp_two; endproperty
a_two: assert property (p_two) else $error("pair flag missing");
property p_neg; c && i_cmd_code == 4'h1 |=> o_neg_prot == $past(i_cmd_value); endproperty
a_neg: assert property (p_neg) else $error("neg limit not stored");
property p_pos; c && i_cmd_code == 4'h2 |=> o_pos_prot == $past(i_cmd_value); endproperty
a_pos: assert property (p_pos) else $error("pos limit not stored");
property p_err; c && i_cmd_code == 4'h6 && i_cmd_value > 16'h03E8 |=>
	o_err_valid && o_err_code == 16'hFF22; endproperty
a_err: assert property (p_err) else $error("range error missing");
property p_hold; !(c && i_cmd_code == 4'h7) |=> $stable(o_setpoint); endproperty
a_hold: assert property (p_hold) else $error("setpoint moved");
property p_save; c && i_cmd_code == 4'h8 |=> o_save_pulse; endproperty
a_save: assert property (p_save) else $error("save pulse missing");
property p_pre; c && i_cmd_code == 4'h9 |=> o_ques_mask == 16'h00FF; endproperty
a_pre: assert property (p_pre) else $error("preset mask wrong");
endmodule
bind vps_bank vps_chk #(.VW(VW)) vps_chk_i (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
	.i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_value(i_cmd_value),
	.i_qry_valid(i_qry_valid), .i_qry_code(i_qry_code), .o_rsp_valid(o_rsp_valid),
	.o_rsp_two(o_rsp_two), .o_setpoint(o_setpoint), .o_neg_prot(o_neg_prot),
	.o_pos_prot(o_pos_prot), .o_save_pulse(o_save_pulse), .o_err_valid(o_err_valid),
	.o_err_code(o_err_code), .o_ques_mask(o_ques_mask));

// file: tb/vps_host.sv
// remote host model issuing commands and queries
`timescale 1ns/100ps
module vps_host(
	input wire i_clk,
	input wire i_rsp_valid,
	input wire i_err_valid,
	output reg o_cmd_valid,
	output reg [3:0] o_cmd_code,
	output reg [15:0] o_cmd_value,
	output reg o_qry_valid,
	output reg [3:0] o_qry_code
);
reg got_err;
initial {o_cmd_valid, o_cmd_code, o_cmd_value, o_qry_valid, o_qry_code} = 0;
task cmd(input [3:0] c, input [15:0] v);
begin
	@(posedge i_clk) #1;
	{o_cmd_valid, o_cmd_code, o_cmd_value} = {1'b1, c, v};
	@(posedge i_clk) #1;
	got_err = i_err_valid;
	o_cmd_valid = 0;
	// released lines flip so a stale value never looks live
	{o_cmd_code, o_cmd_value} = ~{o_cmd_code, o_cmd_value};
end
endtask
task qry(input [3:0] c);
	integer i;
begin
	@(posedge i_clk) #1;
	{o_qry_valid, o_qry_code} = {1'b1, c};
	@(posedge i_clk) #1;
	o_qry_valid = 0;
	o_qry_code = ~c;
	for (i = 0; i < 4 && i_rsp_valid !== 1'b1; i = i + 1)
		@(posedge i_clk) #1;
end
endtask
endmodule

// file: tb/vps_bank_tb.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
module vps_bank_tb;
reg clk = 0, rst = 1;
reg [15:0] ul = 16'h0200, sn = 0, sp = 0, snc = 0, spc = 0;
reg [8:0] fl = 0, f;
reg [79:0] tv = {16'h0100, 16'h0300, 16'h03E8, 16'h03E9, 16'hFFFF};
wire cv, qv, rv, r2, ev, sum, spl;
wire [3:0] cc, qc;
wire [15:0] cval, d0, d1, setp, np, pp, sncw, spcw, ec, qm;
integer m_np, m_pp, m_nc, m_pc, m_pend, m_set = 0, m_mask = 0, m_ev = 0, k, c, v, e;
integer n_errors = 0, checks_done = 0, cyc = 0;
always #2.5 clk = ~clk;
vps_host vps_host_i (.i_clk(clk), .i_rsp_valid(rv), .i_err_valid(ev), .o_cmd_valid(cv),
	.o_cmd_code(cc), .o_cmd_value(cval), .o_qry_valid(qv), .o_qry_code(qc));
vps_bank vps_bank_i (.I_CORE_CLK(clk), .I_RST(rst), .i_cmd_valid(cv), .i_cmd_code(cc),
	.i_cmd_value(cval), .i_qry_valid(qv), .i_qry_code(qc), .i_user_high_voltage_limit(ul),
	.i_saved_neg_prot(sn), .i_saved_pos_prot(sp), .i_saved_neg_ceil(snc),
	.i_saved_pos_ceil(spc), .i_settling_flag(fl[0]), .i_trigger_wait_flag(fl[1]),
	.i_pulse_armed_flag(fl[2]), .i_const_voltage_flag(fl[3]), .i_pulse_done_flag(fl[4]),
	.i_const_current_flag(fl[5]), .i_sample_done_flag(fl[6]), .i_sequence_done_flag(fl[7]),
	.i_sequence_running_flag(fl[8]), .o_rsp_valid(rv), .o_rsp_two(r2), .o_rsp_data0(d0),
	.o_rsp_data1(d1), .o_setpoint(setp), .o_neg_prot(np), .o_pos_prot(pp),
	.o_save_pulse(spl), .o_save_neg_ceil(sncw), .o_save_pos_ceil(spcw), .o_err_valid(ev),
	.o_err_code(ec), .o_oper_summary(sum), .o_ques_mask(qm));
function [15:0] cmap(input [8:0] x);
	cmap = {1'b0, x[8], 1'b0, x[7:3], 1'b0, x[2:1], 3'b0, x[0], 1'b0};
endfunction
task chk(input [15:0] g, input [15:0] x);
begin
	checks_done = checks_done + 1;
	if (g !== x)
	begin
		n_errors = n_errors + 1;
		$display("unexpected at %0t: got %h want %h", $time, g, x);
	end
end
endtask
task q(input [3:0] code, input [15:0] x0, input [15:0] x1);
begin
	vps_host_i.qry(code);
	chk(d0, x0);
	chk(d1, x1);
end
endtask
task end_sim;
begin
	if (n_errors == 0 && checks_done > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
end
endtask
always @(posedge clk)
begin
	cyc = cyc + 1;
	// well above the roughly 500 cycles the sequence needs
	if (cyc == 20000)
	begin
		n_errors = n_errors + 1;
		end_sim;
	end
end
initial
begin
	k = $urandom(99);
	{sn, sp, snc, spc} = {$urandom, $urandom};
	repeat (20) @(posedge clk);
	#1 rst = 0;
	repeat (2) @(posedge clk);
	#1 m_np = sn;
	m_pp = sp;
	m_nc = snc;
	m_pc = spc;
	m_pend = 0;
	chk(np, sn);
	chk(pp, sp);
	q(4'h8, 0, 0);
	for (k = 0; k < 24; k = k + 1)
	begin
		c = 1 + $urandom % 5;
		v = $urandom % 16'h03F3;
		vps_host_i.cmd(c, v);
		if (c == 1) m_np = v;
		if (c == 2) m_pp = v;
		if (c == 3 || c == 4) m_nc = v;
		if (c == 3 || c == 5) m_pc = v;
		q(4'h1, m_np, 0);
		q(4'h2, m_pp, 0);
		q(4'h3, m_pc, m_nc);
		chk(r2, 1);
		q(4'h4, m_nc, 0);
		q(4'h5, m_pc, 0);
	end
	vps_host_i.cmd(4'h3, 16'hFFFF);
	m_nc = 16'h03F2;
	m_pc = 16'h03F2;
	q(4'h3, m_pc, m_nc);
	vps_host_i.cmd(4'h8, 0);
	chk(sncw, m_nc);
	chk(spcw, m_pc);
	for (k = 0; k < 5; k = k + 1)
	begin
		v = tv[k*16 +: 16];
		vps_host_i.cmd(4'h6, v);
		e = v > 16'h03E8;
		chk(vps_host_i.got_err, e);
		if (!e) m_pend = v > ul ? ul : v;
		q(4'h6, m_pend, 0);
		chk(setp, m_set);
		vps_host_i.cmd(4'h7, 0);
		m_set = m_pend;
		chk(setp, m_set);
	end
	chk(ec, 16'hFF22);
	for (k = 0; k < 12; k = k + 1)
	begin
		m_mask = k == 6 ? 16'h2001 : $urandom;
		vps_host_i.cmd(k == 6 ? 4'h9 : 4'hA, m_mask);
		q(4'h8, m_mask, 0);
		f = $urandom;
		m_ev = m_ev | (cmap(f) & ~cmap(fl));
		fl = f;
		repeat (3) @(posedge clk);
		#1 q(4'h7, cmap(fl), 0);
		chk(sum, |(m_ev & m_mask));
		if (k % 3 == 0) q(4'h9, m_ev, 0);
		if (k % 3 == 0) m_ev = 0;
		if (k % 3 == 0) q(4'h9, 0, 0);
	end
	chk(qm, 16'h00FF);
	end_sim;
end
endmodule
